// file: sbt_pkg.sv
/*
 * Package for the serial byte transmitter: status bit weights, parity and
 * interrupt source encodings, bit timing and FIFO defaults.
 * Assumes a single 20 MHz clock and an active-high asynchronous reset.
 */
package sbt_pkg;
	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] IRQ_ON_BUFFER_EMPTY = 8'h00;
	localparam logic [7:0] IRQ_ON_FRAME_DONE = 8'h01;
	localparam logic [7:0] PARITY_OFF = 8'h00;
	localparam logic [7:0] PARITY_EVEN_SEL = 8'h02;
	localparam logic [7:0] PARITY_ODD_SEL = 8'h06;
	localparam logic [7:0] FRAME_DONE_FLAG = 8'h20;
	localparam logic [7:0] HOLDING_EMPTY_FLAG = 8'h10;
	localparam int FRAME_DONE_POS = 5;
	localparam int HOLDING_EMPTY_POS = 4;
	localparam int TX_ENABLE_POS = 0;
	// ----------------------------------------------------------------
	// Timing and sizes
	// ----------------------------------------------------------------
	localparam int CLK_PER_BIT = 8;
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [2:0] {
		SBT_IDLE = 3'b000,
		SBT_START = 3'b001,
		SBT_DATA = 3'b011,
		SBT_PARITY = 3'b010,
		SBT_STOP = 3'b110
	} sbt_state_e;
endpackage

// file: sbt_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; write and read in the same cycle are allowed.
 */
`timescale 1ns/1ps
module sbt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// file: sbt_transmitter.sv
/*
 * Buffered serial byte transmitter: FIFO feeding a one-byte buffer register,
 * shift register with start, data, optional parity and stop bits, status
 * flags cleared on read and a selectable interrupt source.
 * Assumes all inputs synchronous to clk; control bits are plain ports.
 */
// Overview of operation
// - Interrupt source select: 0x00 on buffer empty, 0x01 on frame done.
// - Writing a byte loads it and starts transmission with no other command.
// - Buffer-empty interrupt fires when buffer byte moves into shift register.
// - Status read returns control byte; frame done 0x20, buffer empty 0x10; the code returns only tx_enable (bit 0) with the flags.
// - Status read clears the status flags.
// - Parity encoding: 0x00 none, 0x02 even, 0x06 odd.
// - Transmit enable bit set activates, cleared disables the transmitter.
`timescale 1ns/1ps
module sbt_transmitter #(
	parameter int CLK_PER_BIT = sbt_pkg::CLK_PER_BIT,
	parameter int FIFO_DEPTH = sbt_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_enable,
	input wire logic [7:0] parity_setting,
	input wire logic [7:0] irq_source_select,
	input wire logic irq_enable,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic status_read_op,
	output logic [7:0] status_data,
	output logic serial_out,
	output logic irq
);
	// ----------------------------------------------------------------
	// Input FIFO
	// ----------------------------------------------------------------
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_in_ready;
	logic wr_accept;

	// A byte is taken only on an edge where the registered ready is high
	assign wr_accept = wr_valid && wr_ready;

	sbt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_data(wr_data),
		.in_valid(wr_accept),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ready <= 1'b0;
		end else begin
			// Drop for a cycle after each push so ready never overstates room
			wr_ready <= fifo_in_ready && !wr_accept;
		end
	end

	// ----------------------------------------------------------------
	// Bit clock divider
	// ----------------------------------------------------------------
	localparam int DW = $clog2(CLK_PER_BIT);
	logic [DW-1:0] div_reg;
	logic bit_tick;

	assign bit_tick = tx_enable && (div_reg == DW'(CLK_PER_BIT - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else if (!tx_enable || bit_tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Buffer register
	// ----------------------------------------------------------------
	logic [7:0] buf_reg;
	logic buf_full_reg;
	logic transfer;
	sbt_pkg::sbt_state_e state_reg;
	logic last_bit;

	// Shift register takes the byte at a bit tick when idle or ending a frame
	assign last_bit = (state_reg == sbt_pkg::SBT_STOP);
	assign transfer = bit_tick && buf_full_reg && (state_reg == sbt_pkg::SBT_IDLE || last_bit);
	assign fifo_ready = !buf_full_reg || transfer;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_reg <= 8'h00;
			buf_full_reg <= 1'b0;
		end else if (fifo_valid && fifo_ready) begin
			buf_reg <= fifo_data;
			buf_full_reg <= 1'b1;
		end else if (transfer) begin
			buf_full_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic parity_reg;
	logic parity_on;
	logic parity_odd;
	logic frame_end;

	assign parity_on = (parity_setting == sbt_pkg::PARITY_EVEN_SEL)
		|| (parity_setting == sbt_pkg::PARITY_ODD_SEL);
	assign parity_odd = (parity_setting == sbt_pkg::PARITY_ODD_SEL);
	assign frame_end = bit_tick && last_bit;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= sbt_pkg::SBT_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			parity_reg <= 1'b0;
			serial_out <= sbt_pkg::LINE_IDLE;
		end else if (!tx_enable) begin
			state_reg <= sbt_pkg::SBT_IDLE;
			serial_out <= sbt_pkg::LINE_IDLE;
		end else if (bit_tick) begin
			if (transfer) begin
				state_reg <= sbt_pkg::SBT_START;
				shift_reg <= buf_reg;
				bit_cnt_reg <= 3'h0;
				parity_reg <= parity_odd;
				serial_out <= 1'b0;
			end else begin
				case (state_reg)
					sbt_pkg::SBT_START: begin
						serial_out <= shift_reg[0];
						parity_reg <= parity_reg ^ shift_reg[0];
						shift_reg <= {1'b0, shift_reg[7:1]};
						bit_cnt_reg <= 3'h0;
						state_reg <= sbt_pkg::SBT_DATA;
					end
					sbt_pkg::SBT_DATA: begin
						if (bit_cnt_reg == 3'(sbt_pkg::DATA_BITS - 1)) begin
							if (parity_on) begin
								state_reg <= sbt_pkg::SBT_PARITY;
								serial_out <= parity_reg;
							end else begin
								state_reg <= sbt_pkg::SBT_STOP;
								serial_out <= 1'b1;
							end
						end else begin
							serial_out <= shift_reg[0];
							parity_reg <= parity_reg ^ shift_reg[0];
							shift_reg <= {1'b0, shift_reg[7:1]};
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
						end
					end
					sbt_pkg::SBT_PARITY: begin
						state_reg <= sbt_pkg::SBT_STOP;
						serial_out <= 1'b1;
					end
					sbt_pkg::SBT_STOP: begin
						state_reg <= sbt_pkg::SBT_IDLE;
						serial_out <= sbt_pkg::LINE_IDLE;
					end
					default: begin
						state_reg <= sbt_pkg::SBT_IDLE;
						serial_out <= sbt_pkg::LINE_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags, cleared by a read; a new event wins over the clear
	// ----------------------------------------------------------------
	logic frame_done_reg;
	logic holding_empty_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_done_reg <= 1'b0;
		end else begin
			frame_done_reg <= frame_end || (frame_done_reg && !status_read_op);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holding_empty_reg <= 1'b0;
		end else begin
			holding_empty_reg <= transfer || (holding_empty_reg && !status_read_op);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_data <= 8'h00;
		end else if (status_read_op) begin
			status_data <= (frame_done_reg ? sbt_pkg::FRAME_DONE_FLAG : 8'h00)
				| (holding_empty_reg ? sbt_pkg::HOLDING_EMPTY_FLAG : 8'h00)
				| {7'h00, tx_enable};
		end
	end

	// ----------------------------------------------------------------
	// Interrupt: one-cycle pulse from the selected source
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (irq_source_select == sbt_pkg::IRQ_ON_FRAME_DONE) begin
			irq <= irq_enable && frame_end;
		end else begin
			irq <= irq_enable && transfer;
		end
	end
endmodule

// file: sbt_transmitter_monitor.sv
/* Checker for the serial byte transmitter top ports.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
module sbt_tx_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_enable,
	input wire logic [7:0] irq_source_select,
	input wire logic irq_enable,
	input wire logic serial_out,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_low_len;
		$fell(serial_out) |-> (!serial_out) [*8];
	endproperty
	a_low_len: assert property (p_low_len) else $error("low bit too short");
	property p_high_len;
		$rose(serial_out) |-> serial_out [*8];
	endproperty
	a_high_len: assert property (p_high_len) else $error("high bit too short");
	property p_off_idle;
		!tx_enable && !$past(tx_enable) |-> serial_out;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("line busy while off");
	property p_go_en;
		$fell(serial_out) |-> tx_enable;
	endproperty
	a_go_en: assert property (p_go_en) else $error("frame while off");
	property p_irq_mask;
		!irq_enable && !$past(irq_enable) |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
	property p_irq_en;
		$rose(irq) |-> $past(irq_enable);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq not enabled");
	property p_irq_empty;
		$rose(irq) && irq_source_select == sbt_pkg::IRQ_ON_BUFFER_EMPTY |-> !serial_out;
	endproperty
	a_irq_empty: assert property (p_irq_empty) else $error("irq off start");
	property p_irq_done;
		$rose(irq) && irq_source_select == sbt_pkg::IRQ_ON_FRAME_DONE |-> $past(serial_out);
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("irq mid frame");
endmodule
bind sbt_transmitter sbt_tx_monitor mon (.clk(clk), .rst(rst), .tx_enable(tx_enable),
	.irq_source_select(irq_source_select), .irq_enable(irq_enable),
	.serial_out(serial_out), .irq(irq));

// file: sbt_line_rx_model.sv
/* Serial line receiver model: stores data, parity and stop bits of each frame.
   Assumes an idle-high line and CPB clocks per bit. */
`timescale 1ns/1ps
module sbt_line_rx_model #(
	parameter int CPB = 8
) (
	input wire logic clk,
	input wire logic line,
	input wire logic par_on,
	output int cnt
);
	logic [7:0] got[64];
	logic gpar[64];
	logic gstop[64];
	initial cnt = 0;
	always begin
		@(negedge line);
		repeat (CPB / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (CPB) @(posedge clk);
			got[cnt][i] = line;
		end
		if (par_on) begin
			repeat (CPB) @(posedge clk);
			gpar[cnt] = line;
		end
		repeat (CPB) @(posedge clk);
		gstop[cnt] = line;
		cnt = cnt + 1;
	end
endmodule

// file: tb_top.sv
/* Self-checking bench for the serial byte transmitter.
   Assumes the line receiver model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, tx_enable, irq_enable, wr_valid, wr_ready, status_read_op, serial_out, irq, seen;
	logic [7:0] parity_setting, irq_source_select, wr_data, status_data, d, s, par;
	int failures, cmp_count, seed, k, cyc;
	logic [7:0] q[12];
	sbt_transmitter dut (.clk(clk), .rst(rst), .tx_enable(tx_enable),
		.parity_setting(parity_setting), .irq_source_select(irq_source_select),
		.irq_enable(irq_enable), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.status_read_op(status_read_op), .status_data(status_data),
		.serial_out(serial_out), .irq(irq));
	sbt_line_rx_model rx (.clk(clk), .line(serial_out), .par_on(parity_setting != 8'h00),
		.cnt());
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq === 1'b1) seen <= 1'b1;
		if (cyc == 10000) begin
			failures++;
			close_out;
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Holds valid up; caller lowers it
	task put(input logic [7:0] v);
		wr_data <= v;
		wr_valid <= 1;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			if (wr_ready === 1'b1) break;
		end
	endtask
	task wait_rx(input int n);
		for (int i = 0; i < 2000 && rx.cnt < n; i++) @(posedge clk);
		chk(rx.cnt >= n ? 8'h01 : 8'h00, 8'h01);
	endtask
	task rd(output logic [7:0] r);
		status_read_op <= 1;
		@(posedge clk);
		status_read_op <= 0;
		@(posedge clk);
		#1 r = status_data;
	endtask
	function logic [7:0] xp(input logic [7:0] v, input logic [7:0] p);
		return {7'h00, (p == sbt_pkg::PARITY_ODD_SEL) ? ~^v : ^v};
	endfunction
	initial begin
		{tx_enable, irq_enable, wr_valid, status_read_op, seen, cyc, k} = 0;
		{parity_setting, irq_source_select, wr_data} = 0;
		{failures, cmp_count} = 0;
		seed = 32'hd340;
		rst = 1;
		repeat (8) @(posedge clk);
		rst <= 0;
		irq_enable <= 1;
		for (int m = 0; m < 6; m++) begin
			par = (m % 3 == 0) ? sbt_pkg::PARITY_OFF
				: (m % 3 == 1) ? sbt_pkg::PARITY_EVEN_SEL : sbt_pkg::PARITY_ODD_SEL;
			tx_enable <= 0;
			parity_setting <= par;
			irq_source_select <= m < 3 ? sbt_pkg::IRQ_ON_BUFFER_EMPTY : sbt_pkg::IRQ_ON_FRAME_DONE;
			repeat (2) @(posedge clk);
			tx_enable <= 1;
			seen <= 0;
			d = $random(seed);
			put(d);
			wr_valid <= 0;
			wait_rx(k + 1);
			chk(rx.got[k], d);
			if (par != 8'h00) chk({7'h00, rx.gpar[k]}, xp(d, par));
			chk({7'h00, rx.gstop[k]}, 8'h01);
			// Stop bit is sampled mid-bit; let the frame finish first
			repeat (8) @(posedge clk);
			rd(s);
			chk(s & 8'h31, 8'h31);
			rd(s);
			chk(s & 8'h30, 8'h00);
			chk({7'h00, seen}, 8'h01);
			k++;
			$display("case %0d done", m);
		end
		// Burst past FIFO depth, host waits on ready each time
		for (int i = 0; i < 12; i++) begin
			q[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			put(q[i]);
		end
		wr_valid <= 0;
		wait_rx(k + 12);
		for (int i = 0; i < 12; i++) chk(rx.got[k + i], q[i]);
		$display("burst done");
		close_out;
	end
endmodule
